// ===== dmc_pkg.sv
// Purpose: constants shared by the decimation and mode control block
// Assumes: core clock of 250 MHz, AXI4-Lite register access
// Notes: decimation table maps the 4-bit select onto ratio and gain
// Function
// - every channel owns a sinc3 decimator fed by its modulator bitstream
// - ratio equals fmod over data rate, one 4-bit select for all channels
// - response is K times cube of (1-z^-N) over N(1-z^-1)
// - K is 0.9983778, 1.0 or 1.00195313 depending on ratio family
// - nulls fall on the data rate and every multiple of it
// - results flow at once after wake; third result is first settled
// - decimation path is linear phase with constant group delay
// - watchdog is a 16-bit counter stepped by an internal 50 kHz tick
// - each falling chip select restarts the watchdog; host frames often
// - no restart within 500 ms resets device and sets watchdog flag
// - high-resolution select caps fmod at 4.25 MHz, else 1.05 MHz
// - power-on reset loads defaults, latches mode pins, locks, standby
// - power-on initialisation completes within 4.5 ms
// - after init device answers ready; host must unlock first
// - startup status records good power-up or the fault seen
// - after unlock or reset channels are down; enable all then wake
// - conversion is continuous; each result offered at next data ready
// - reset by pin held low or by reset command at its completion
// - pin or command reset restores defaults, latches pins, locks
// - results are 24-bit twos complement, cut to 16 or padded to 32
`default_nettype none
package dmc_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int INIT_TIME_US = 4500;
  localparam int INIT_CYCLES = CLK_HZ / 1_000_000 * INIT_TIME_US;
  localparam int WD_TICK_HZ = 50_000;
  localparam int WD_TICK_CYCLES = CLK_HZ / WD_TICK_HZ;
  localparam int WD_TIMEOUT_MS = 500;
  localparam int WD_TIMEOUT_TICKS = WD_TICK_HZ / 1000 * WD_TIMEOUT_MS;
  localparam int FMOD_HR_HZ = 4_250_000;
  localparam int FMOD_LP_HZ = 1_050_000;
  localparam int MOD_MIN_HR = (CLK_HZ + FMOD_HR_HZ - 1) / FMOD_HR_HZ;
  localparam int MOD_MIN_LP = (CLK_HZ + FMOD_LP_HZ - 1) / FMOD_LP_HZ;
  localparam int ACC_W = 38;
  localparam int RES_W = 24;
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_ANALOG_CFG = 5'h04;
  localparam logic [4:0] ADDR_DIGITAL_CFG = 5'h08;
  localparam logic [4:0] ADDR_CLOCK_CFG2 = 5'h0c;
  localparam logic [4:0] ADDR_CH_ENABLE = 5'h10;
  localparam logic [4:0] ADDR_STARTUP = 5'h14;
  localparam logic [4:0] ADDR_MODE_PINS = 5'h18;
  localparam int ST_WDFLAG = 0;
  localparam int ST_READY = 1;
  localparam int ST_UNLOCKED = 2;
  localparam int ST_CONVERT = 3;
  localparam int ST_SETTLED = 4;
  localparam int RATIO_LSB = 0;
  localparam int MODDIV_LSB = 8;
  localparam logic [3:0] RATIO_SEL_RST = 4'h5;
  localparam logic [7:0] MODDIV_RST = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] PINB_LOW = 2'h0;
  localparam logic [1:0] PINB_HIGH = 2'h1;
  localparam logic [1:0] PINB_FLOAT = 2'h2;

  // ratio = a * 2^b with a in {1,3,25}; gain K/a^3 = mul / 2^f
  function automatic logic [12:0] dmc_ratio(input logic [3:0] sel);
    case (sel)
      4'h0: dmc_ratio = 13'd4096;  4'h1: dmc_ratio = 13'd2048;
      4'h2: dmc_ratio = 13'd1024;  4'h3: dmc_ratio = 13'd800;
      4'h4: dmc_ratio = 13'd768;   4'h5: dmc_ratio = 13'd512;
      4'h6: dmc_ratio = 13'd400;   4'h7: dmc_ratio = 13'd384;
      4'h8: dmc_ratio = 13'd256;   4'h9: dmc_ratio = 13'd200;
      4'ha: dmc_ratio = 13'd192;   4'hb: dmc_ratio = 13'd128;
      4'hc: dmc_ratio = 13'd96;    4'hd: dmc_ratio = 13'd64;
      4'he: dmc_ratio = 13'd48;    default: dmc_ratio = 13'd32;
    endcase
  endfunction

  function automatic logic [6:0] dmc_gain_mul(input logic [3:0] sel);
    case (sel)
      4'h3, 4'h6, 4'h9: dmc_gain_mul = 7'h43;
      4'h4, 4'h7, 4'ha, 4'hc, 4'he: dmc_gain_mul = 7'h13;
      default: dmc_gain_mul = 7'h01;
    endcase
  endfunction

  function automatic logic [5:0] dmc_shift(input logic [3:0] sel);
    case (sel)
      4'h0: dmc_shift = 6'd45;  4'h1: dmc_shift = 6'd42;
      4'h2: dmc_shift = 6'd39;  4'h3: dmc_shift = 6'd44;
      4'h4: dmc_shift = 6'd42;  4'h5: dmc_shift = 6'd36;
      4'h6: dmc_shift = 6'd41;  4'h7: dmc_shift = 6'd39;
      4'h8: dmc_shift = 6'd33;  4'h9: dmc_shift = 6'd38;
      4'ha: dmc_shift = 6'd36;  4'hb: dmc_shift = 6'd30;
      4'hc: dmc_shift = 6'd33;  4'hd: dmc_shift = 6'd27;
      4'he: dmc_shift = 6'd30;  default: dmc_shift = 6'd24;
    endcase
  endfunction

  typedef enum logic [1:0] {
    ST_INIT, ST_LOCKED, ST_STANDBY, ST_CONV
  } dmc_state_e;
endpackage
`default_nettype wire

// ===== dmc_top.sv
// Purpose: sinc3 decimators plus reset, standby, wake and watchdog control
// Assumes: command pulses come from interface logic on core_clk
// Notes: pins and modulator bits pass two flip-flops before use
`default_nettype none
module dmc_top #(
  parameter int NCH = 4,
  parameter int INIT_CYCLES = dmc_pkg::INIT_CYCLES,
  parameter int WD_TICK_CYCLES = dmc_pkg::WD_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [NCH-1:0] modBits,
  input wire logic resetPinN,
  input wire logic csN,
  input wire logic modeSelectPinA,
  input wire logic [1:0] modeSelectPinB,
  input wire logic modeSelectPinC,
  input wire logic wakeCommand,
  input wire logic standbyCommand,
  input wire logic resetCommand,
  input wire logic unlockCommand,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NCH*32-1:0] channelWords,
  output logic dataReady,
  output logic resultSettled,
  output logic readyStatus,
  output logic interfaceUnlocked,
  output logic converting,
  output logic modClkEn
);
  localparam int AW = dmc_pkg::ACC_W;
  localparam int RW = dmc_pkg::RES_W;

  if (NCH < 1 || NCH > 8) begin : g_chk_nch
    $error("NCH must be 1 to 8");
  end
  if (INIT_CYCLES < 4 || WD_TICK_CYCLES < 2) begin : g_chk_cnt
    $error("counts too small");
  end

  // synchronisers: first stage feeds only the second
  logic [NCH+5:0] syncA_r, syncB_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= '1;
      syncB_r <= '1;
    end else begin
      syncA_r <= {modeSelectPinC, modeSelectPinB, modeSelectPinA, csN,
                  resetPinN, modBits};
      syncB_r <= syncA_r;
    end
  end
  logic [NCH-1:0] modSync;
  logic resetPinSync, csSync, csPrev_r, csFall;
  logic [3:0] pinsSync;
  assign modSync = syncB_r[NCH-1:0];
  assign resetPinSync = syncB_r[NCH];
  assign csSync = syncB_r[NCH+1];
  assign pinsSync = syncB_r[NCH+5:NCH+2];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) csPrev_r <= 1'b1;
    else csPrev_r <= csSync;
  end
  assign csFall = csPrev_r && !csSync;

  dmc_pkg::dmc_state_e state_r;
  logic softRst, wdExpire;
  // pin reset holds while low; command and watchdog act as a pulse
  assign softRst = !resetPinSync || resetCommand || wdExpire;

  // software registers, restored by every reset source except the watchdog flag
  logic highResSel_r, wdEnable_r;
  logic [3:0] ratioSel_r;
  logic [7:0] modDiv_r;
  logic [NCH-1:0] chEnable_r;
  logic wdFlag_r;
  logic [4:0] startup_r;
  logic [3:0] pinsLatched_r;
  logic wrDo, rdDo;
  logic [4:0] awAddr_r, arAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awHave_r, wHave_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      highResSel_r <= 1'b0;
      wdEnable_r <= 1'b0;
      ratioSel_r <= dmc_pkg::RATIO_SEL_RST;
      modDiv_r <= dmc_pkg::MODDIV_RST;
      chEnable_r <= '0;
    end else if (softRst) begin
      highResSel_r <= 1'b0;
      wdEnable_r <= 1'b0;
      ratioSel_r <= dmc_pkg::RATIO_SEL_RST;
      modDiv_r <= dmc_pkg::MODDIV_RST;
      chEnable_r <= '0;
    end else if (wrDo && interfaceUnlocked && wStrb_r[0]) begin
      // writes land only once the interface is unlocked
      case (awAddr_r)
        dmc_pkg::ADDR_ANALOG_CFG: highResSel_r <= wData_r[0];
        dmc_pkg::ADDR_DIGITAL_CFG: wdEnable_r <= wData_r[0];
        dmc_pkg::ADDR_CLOCK_CFG2: ratioSel_r <= wData_r[3:0];
        dmc_pkg::ADDR_CH_ENABLE: chEnable_r <= wData_r[NCH-1:0];
        default: ;
      endcase
      if (awAddr_r == dmc_pkg::ADDR_CLOCK_CFG2 && wStrb_r[1])
        modDiv_r <= wData_r[15:8];
    end else if (wrDo && interfaceUnlocked && wStrb_r[1] &&
                 awAddr_r == dmc_pkg::ADDR_CLOCK_CFG2) begin
      modDiv_r <= wData_r[15:8];
    end
  end

  // watchdog flag survives the reset it reports; set beats clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) wdFlag_r <= 1'b0;
    else if (wdExpire) wdFlag_r <= 1'b1;
    else if (wrDo && wStrb_r[0] && awAddr_r == dmc_pkg::ADDR_STATUS &&
             wData_r[dmc_pkg::ST_WDFLAG])
      wdFlag_r <= 1'b0;
  end

  // operating state
  logic [$clog2(INIT_CYCLES+1)-1:0] initCnt_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= dmc_pkg::ST_INIT;
      initCnt_r <= '0;
    end else if (softRst) begin
      state_r <= dmc_pkg::ST_INIT;
      initCnt_r <= '0;
    end else begin
      case (state_r)
        dmc_pkg::ST_INIT: begin
          if (initCnt_r == ($clog2(INIT_CYCLES+1))'(INIT_CYCLES - 1))
            state_r <= dmc_pkg::ST_LOCKED;
          else
            initCnt_r <= initCnt_r + 1'b1;
        end
        dmc_pkg::ST_LOCKED: begin
          if (unlockCommand) state_r <= dmc_pkg::ST_STANDBY;
        end
        dmc_pkg::ST_STANDBY: begin
          // partial enables do not start conversion
          if (wakeCommand && &chEnable_r) state_r <= dmc_pkg::ST_CONV;
        end
        dmc_pkg::ST_CONV: begin
          if (standbyCommand) state_r <= dmc_pkg::ST_STANDBY;
        end
        default: state_r <= dmc_pkg::ST_INIT;
      endcase
    end
  end

  // mode pins caught early in init, once the sync stages hold them
  logic [2:0] resetCause_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinsLatched_r <= '0;
      startup_r <= '0;
      resetCause_r <= '0;
    end else begin
      if (softRst)
        resetCause_r <= {resetCommand, !resetPinSync, wdExpire};
      if (state_r == dmc_pkg::ST_INIT &&
          initCnt_r == ($clog2(INIT_CYCLES+1))'(2))
        pinsLatched_r <= pinsSync;
      if (softRst)
        startup_r <= '0;
      else if (state_r == dmc_pkg::ST_INIT &&
               initCnt_r == ($clog2(INIT_CYCLES+1))'(INIT_CYCLES - 1))
        // bit0 good, bit4 undefined word-length pin code
        startup_r <= {pinsLatched_r[2:1] == 2'h3, resetCause_r,
                      pinsLatched_r[2:1] != 2'h3};
    end
  end

  // watchdog on a 50 kHz tick enable
  logic [$clog2(WD_TICK_CYCLES)-1:0] tickCnt_r;
  logic [15:0] wdCnt_r;
  logic wdRun;
  assign wdRun = wdEnable_r && state_r != dmc_pkg::ST_INIT;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= '0;
      wdCnt_r <= '0;
    end else if (!wdRun || csFall || softRst) begin
      tickCnt_r <= '0;
      wdCnt_r <= '0;
    end else if (tickCnt_r ==
                 ($clog2(WD_TICK_CYCLES))'(WD_TICK_CYCLES - 1)) begin
      tickCnt_r <= '0;
      wdCnt_r <= wdCnt_r + 16'h0001;
    end else begin
      tickCnt_r <= tickCnt_r + 1'b1;
    end
  end
  assign wdExpire = wdRun && !csFall &&
                    wdCnt_r == 16'(dmc_pkg::WD_TIMEOUT_TICKS);

  // modulator rate enable; floor keeps fmod within the mode's limit
  logic [7:0] modCnt_r, modPeriod;
  always_comb begin
    modPeriod = modDiv_r;
    if (highResSel_r && modDiv_r < 8'(dmc_pkg::MOD_MIN_HR))
      modPeriod = 8'(dmc_pkg::MOD_MIN_HR);
    if (!highResSel_r && modDiv_r < 8'(dmc_pkg::MOD_MIN_LP))
      modPeriod = 8'(dmc_pkg::MOD_MIN_LP);
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modCnt_r <= '0;
      modClkEn <= 1'b0;
    end else if (modCnt_r >= modPeriod - 8'h01) begin
      modCnt_r <= '0;
      modClkEn <= 1'b1;
    end else begin
      modCnt_r <= modCnt_r + 8'h01;
      modClkEn <= 1'b0;
    end
  end

  // shared decimation counter: all channels run at one data rate
  logic [12:0] decCnt_r, ratioN;
  logic decEn, running;
  assign ratioN = dmc_pkg::dmc_ratio(ratioSel_r);
  assign running = state_r == dmc_pkg::ST_CONV;
  assign decEn = running && modClkEn && decCnt_r >= ratioN - 13'h0001;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) decCnt_r <= '0;
    else if (!running) decCnt_r <= '0;
    else if (decEn) decCnt_r <= '0;
    else if (modClkEn) decCnt_r <= decCnt_r + 13'h0001;
  end

  logic [1:0] wordLen;
  assign wordLen = pinsLatched_r[2:1];

  // per-channel sinc3: integrate at fmod, comb at data rate; symmetric
  // boxcar taps give linear phase, and wrap-around integrators are exact
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic signed [AW-1:0] int1_r, int2_r, int3_r;
    logic signed [AW-1:0] dly1_r, dly2_r, dly3_r;
    logic signed [AW-1:0] comb1, comb2, comb3, sample, int3Nxt;
    logic signed [AW+7:0] prod;
    logic signed [AW+39:0] scaled;
    logic signed [RW-1:0] result;
    assign sample = modSync[ch] ? AW'(1) : -AW'(1);
    // comb reads the updated sum so the third result spans 3N samples
    assign int3Nxt = int3_r + int2_r;
    assign comb1 = int3Nxt - dly1_r;
    assign comb2 = comb1 - dly2_r;
    assign comb3 = comb2 - dly3_r;
    assign prod = comb3 * $signed({1'b0, dmc_pkg::dmc_gain_mul(ratioSel_r)});
    assign scaled = $signed({prod, 32'h0}) >>>
                    dmc_pkg::dmc_shift(ratioSel_r);
    // full scale clips to the extreme codes
    always_comb begin
      if (scaled > (AW+40)'(24'sh7fffff)) result = 24'sh7fffff;
      else if (scaled < (AW+40)'(24'sh800000)) result = 24'sh800000;
      else result = scaled[RW-1:0];
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        {int1_r, int2_r, int3_r} <= '0;
        {dly1_r, dly2_r, dly3_r} <= '0;
      end else if (!running) begin
        {int1_r, int2_r, int3_r} <= '0;
        {dly1_r, dly2_r, dly3_r} <= '0;
      end else if (modClkEn) begin
        int1_r <= int1_r + sample;
        int2_r <= int2_r + int1_r;
        int3_r <= int3Nxt;
        if (decEn) begin
          dly1_r <= int3Nxt;
          dly2_r <= comb1;
          dly3_r <= comb2;
        end
      end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) channelWords[ch*32 +: 32] <= '0;
      else if (decEn) begin
        case (wordLen)
          dmc_pkg::PINB_HIGH:
            channelWords[ch*32 +: 32] <= {result, 8'h00};
          dmc_pkg::PINB_FLOAT:
            channelWords[ch*32 +: 32] <= {16'h0000, result[RW-1:8]};
          default:
            channelWords[ch*32 +: 32] <= {8'h00, result};
        endcase
      end
    end
  end

  // results released unconditionally; settled from the third on
  logic [1:0] resCnt_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resCnt_r <= '0;
      dataReady <= 1'b0;
      resultSettled <= 1'b0;
    end else begin
      dataReady <= decEn;
      if (!running) begin
        resCnt_r <= '0;
        resultSettled <= 1'b0;
      end else if (decEn) begin
        if (resCnt_r != 2'h3) resCnt_r <= resCnt_r + 2'h1;
        resultSettled <= resCnt_r >= 2'h2;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      readyStatus <= 1'b0;
      interfaceUnlocked <= 1'b0;
      converting <= 1'b0;
    end else begin
      readyStatus <= !softRst && state_r == dmc_pkg::ST_LOCKED;
      interfaceUnlocked <= !softRst && (state_r == dmc_pkg::ST_STANDBY ||
                           state_r == dmc_pkg::ST_CONV);
      converting <= !softRst && running;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign wrDo = awHave_r && wHave_r && !s_axi_bvalid;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dmc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_r && !s_axi_awready;
      s_axi_wready <= !wHave_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrDo) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r[1:0] == 2'h0 &&
                        awAddr_r <= dmc_pkg::ADDR_MODE_PINS) ?
                       dmc_pkg::RESP_OKAY : dmc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read
  logic [31:0] rdWord;
  logic rdHit;
  always_comb begin
    rdWord = 32'h0;
    rdHit = 1'b1;
    case (arAddr_r)
      dmc_pkg::ADDR_STATUS:
        rdWord = {27'h0, resultSettled, converting, interfaceUnlocked,
                  readyStatus, wdFlag_r};
      dmc_pkg::ADDR_ANALOG_CFG: rdWord = {31'h0, highResSel_r};
      dmc_pkg::ADDR_DIGITAL_CFG: rdWord = {31'h0, wdEnable_r};
      dmc_pkg::ADDR_CLOCK_CFG2: rdWord = {16'h0, modDiv_r, 4'h0, ratioSel_r};
      dmc_pkg::ADDR_CH_ENABLE: rdWord = 32'(chEnable_r);
      dmc_pkg::ADDR_STARTUP: rdWord = {27'h0, startup_r};
      dmc_pkg::ADDR_MODE_PINS: rdWord = {28'h0, pinsLatched_r};
      default: rdHit = 1'b0;
    endcase
  end
  assign rdDo = s_axi_arvalid && s_axi_arready;
  logic rdPend_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arAddr_r <= '0;
      rdPend_r <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= dmc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !rdPend_r && !s_axi_rvalid && !s_axi_arready;
      if (rdDo) begin
        arAddr_r <= s_axi_araddr;
        rdPend_r <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (rdPend_r) begin
        rdPend_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdHit ? dmc_pkg::RESP_OKAY : dmc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // dmc_top
`default_nettype wire

// ===== dmc_top_chk.sv
// Purpose: temporal checks on dmc_top ports
// Assumes: one clock domain, rst_n async active low
// Notes: init length is counted locally
`default_nettype none
module dmc_top_chk #(
  parameter int INIT_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic unlockCommand,
  input wire logic standbyCommand,
  input wire logic resetCommand,
  input wire logic readyStatus,
  input wire logic interfaceUnlocked,
  input wire logic converting,
  input wire logic dataReady,
  input wire logic resultSettled,
  input wire logic modClkEn
);
  timeunit 1ns;
  timeprecision 1ps;
  int initCnt_r;
  wire logic inInit = !readyStatus && !interfaceUnlocked && !converting;
  // counts cycles spent neither ready nor unlocked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      initCnt_r <= 0;
    end else begin
      initCnt_r <= inInit ? initCnt_r + 1 : 0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // margin covers pin sync and a held reset pin
  AST_INIT_MAX: assert property (initCnt_r < INIT_CYCLES + 16)
    else $error("init ran too long");
  AST_INIT_MIN: assert property ($rose(readyStatus) |->
    initCnt_r >= INIT_CYCLES - 4) else $error("ready came too early");
  AST_MOD_GAP: assert property (modClkEn |=> !modClkEn [*8])
    else $error("modulator enable too dense");
  AST_DR_PULSE: assert property (dataReady |->
    converting ##1 !dataReady) else $error("data ready not a pulse");
  AST_CONV_UNL: assert property (converting |-> interfaceUnlocked)
    else $error("converting while locked");
  AST_READY_LOCK: assert property (readyStatus |->
    !interfaceUnlocked && !converting) else $error("ready while unlocked");
  AST_UNLOCK: assert property (unlockCommand && readyStatus &&
    !resetCommand |-> ##2 interfaceUnlocked) else $error("unlock lost");
  AST_STANDBY: assert property (standbyCommand && converting &&
    !resetCommand |-> ##2 !converting) else $error("standby lost");
  AST_RESET: assert property (resetCommand |-> ##2
    !(interfaceUnlocked || readyStatus || converting))
    else $error("reset command lost");
  CVR_SETTLED: cover property ($rose(resultSettled));
  CVR_STOP: cover property ($fell(converting));
  CVR_UNLOCK: cover property ($rose(interfaceUnlocked));
endmodule // dmc_top_chk
bind dmc_top dmc_top_chk #(.INIT_CYCLES(INIT_CYCLES)) chk_u (
  .core_clk, .rst_n, .unlockCommand, .standbyCommand, .resetCommand,
  .readyStatus, .interfaceUnlocked, .converting, .dataReady,
  .resultSettled, .modClkEn
);
`default_nettype wire

// ===== dmc_host.sv
// Purpose: host stand-in opening frames and issuing commands
// Assumes: commands are one-cycle pulses on core_clk
// Notes: chip select idles high between frames
`default_nettype none
module dmc_host (
  input wire logic core_clk,
  output logic csN,
  output logic unlockCommand,
  output logic wakeCommand,
  output logic standbyCommand,
  output logic resetCommand
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    csN = 1'b1;
    {unlockCommand, wakeCommand, standbyCommand, resetCommand} = 4'h0;
  end
  // one-hot cmd: unlock, wake, standby, reset
  task automatic frame(input logic [3:0] cmd);
    @(posedge core_clk);
    csN <= 1'b0;
    @(posedge core_clk);
    {unlockCommand, wakeCommand, standbyCommand, resetCommand} <= cmd;
    @(posedge core_clk);
    {unlockCommand, wakeCommand, standbyCommand, resetCommand} <= 4'h0;
    csN <= 1'b1;
    // outputs follow two edges after the pulse
    repeat (3) @(posedge core_clk);
  endtask
endmodule // dmc_host
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for dmc_top
// Assumes: short init and tick counts for simulation
// Notes: watchdog expiry is too long to reach here
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, resetPinN, modeSelectPinA, modeSelectPinC;
  logic [1:0] modeSelectPinB, s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] modBits, s_axi_wstrb;
  logic csN, wakeCommand, standbyCommand, resetCommand, unlockCommand;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, dataReady, resultSettled;
  logic readyStatus, interfaceUnlocked, converting, modClkEn;
  logic [127:0] channelWords;
  int n_mismatch, n_tests, cyc, t0;
  dmc_top #(.NCH(4), .INIT_CYCLES(50), .WD_TICK_CYCLES(4)) dut_u (.*);
  dmc_host host_u (.*);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, dmc_pkg::RESP_OKAY);
    @(posedge core_clk);
  endtask
  task automatic axr(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e,
                       input logic [1:0] r);
    axr(a);
    chk(rd, e);
    chk(rs, r);
  endtask
  task automatic waitDr;
    do @(posedge core_clk); while (dataReady !== 1'b1);
  endtask
  task automatic waitRdy;
    while (readyStatus !== 1'b1) @(posedge core_clk);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // about 50k cycles, well past the expected run
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    resetPinN = 1'b1;
    {modeSelectPinC, modeSelectPinB, modeSelectPinA} = 4'hb;
    modBits = 4'h5;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    waitRdy();
    chk(interfaceUnlocked, 1'b0);
    axw(5'h0c, 32'h0000000f);
    rdchk(5'h0c, 32'h0000ff05, 2'h0);
    rdchk(5'h1c, 32'h0, dmc_pkg::RESP_SLVERR);
    rdchk(5'h18, 32'hb, 2'h0);
    host_u.frame(4'h8);
    chk(interfaceUnlocked, 1'b1);
    axw(5'h08, 32'h1);
    rdchk(5'h08, 32'h1, 2'h0);
    host_u.frame(4'h4);
    chk(converting, 1'b0);
    // later pin changes must not reach the latched copy
    {modeSelectPinC, modeSelectPinB, modeSelectPinA} <= 4'h0;
    // byte lane 1 alone must leave the ratio select untouched
    s_axi_wstrb <= 4'h2;
    axw(5'h0c, 32'h00003b0f);
    rdchk(5'h0c, 32'h00003b05, 2'h0);
    s_axi_wstrb <= 4'hf;
    axw(5'h04, 32'h1);
    axw(5'h0c, 32'hf);
    axw(5'h10, 32'hf);
    host_u.frame(4'h4);
    chk(converting, 1'b1);
    waitDr();
    waitDr();
    t0 = cyc;
    chk(resultSettled, 1'b0);
    waitDr();
    chk(cyc - t0, 32 * 59);
    chk(channelWords[31:0], 32'h7fffff00);
    chk(channelWords[63:32], 32'h80000000);
    repeat (2) @(posedge core_clk);
    chk(resultSettled, 1'b1);
    rdchk(5'h18, 32'hb, 2'h0);
    rdchk(5'h00, 32'h1c, 2'h0);
    // swap polarities; four results flush the old input from the window
    modBits <= 4'ha;
    repeat (4) waitDr();
    chk(channelWords[31:0], 32'h80000000);
    chk(channelWords[63:32], 32'h7fffff00);
    host_u.frame(4'h2);
    chk(converting, 1'b0);
    axw(5'h10, 32'h0);
    host_u.frame(4'h1);
    chk(interfaceUnlocked, 1'b0);
    waitRdy();
    rdchk(5'h0c, 32'h0000ff05, 2'h0);
    rdchk(5'h18, 32'h0, 2'h0);
    axr(5'h14);
    chk(rd[3], 1'b1);
    resetPinN <= 1'b0;
    repeat (4) @(posedge core_clk);
    resetPinN <= 1'b1;
    // give the pin sync time to drop ready first
    repeat (4) @(posedge core_clk);
    waitRdy();
    axr(5'h14);
    chk(rd[2], 1'b1);
    test_done();
  end
endmodule // tb
`default_nettype wire
